// file: design/rtc_prescaler.sv
/*
 Prescaler, square-wave pin, interrupt flags and external-tick test mode
 of a real-time clock.
 Assumes the serial interface core drives the register port on clk, the
 alarm and countdown cores send one-cycle events on clk, and the pins are
 resolved outside from the open-drain enables.
*/
// How it works
// - Two select bits pick 32.768 kHz, 1.024 kHz, 32 Hz or 1 Hz output
// - Square-wave pin is open-drain only; disabled means released
// - Alarm and countdown events set sticky flags held until written
// - Flag write ANDs each flag with the written bit
// - Alarm flag at bit 3, countdown flag at bit 2 of control two
// - Alarm enable gates its flag, countdown enable its flag (level) or pulse (pulse mode), onto the interrupt pin, ORed together
// - Pulse width depends on countdown source and on count being one
// - In pulse mode flag and interrupt pin go active together
// - Zero countdown value gives no flag and no pulse
// - Test bit makes square-wave pin an input replacing the 64 Hz stage
// - In test mode 64 pin rising edges advance time by one second
// - Halt holds stages 2 to 14 of the divide chain at zero until software clears it
// - After halt release in test mode first tick after 32 pin edges, then every 64
// - Entering test mode neither resets nor resynchronises the prescaler
// - Halt clears stages 2 to 14 and suppresses every second tick
// - During halt 32.768 kHz output runs, slower outputs stop
// - Halt leaves the two lowest stages running
// - Second tick on each rising transition of the top stage
// - Interrupt pin open-drain active low; pulse or level mode
`timescale 1ns/1ps
`include "rtc_prescaler_defines.svh"

module rtc_prescaler (
    input wire logic clk,
    input wire logic rstn,
    input wire logic xtal_in,
    input wire logic square_wave_enable_pin,
    input wire logic square_wave_pin_in,
    output logic square_wave_pin_out,
    output logic square_wave_pin_oe_n,
    output logic irq_pin_out,
    output logic irq_pin_oe_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    input wire logic alarm_event,
    input wire logic countdown_done,
    input wire rtc_prescaler_pkg::count_src_t countdown_source_sel,
    input wire logic [7:0] countdown_value,
    output logic second_tick
);
    import rtc_prescaler_pkg::*;

    state_t q;
    state_t d;
    logic xtal_edge;
    logic ext_edge;
    logic wave;
    logic wr_ctrl1;
    logic wr_ctrl2;
    logic timer_set;
    logic timer_irq;
    logic [9:0] pulse_width;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.xs1 = xtal_in;
        d.xs2 = q.xs1;
        d.xs3 = q.xs2;
        d.es1 = square_wave_pin_in;
        d.es2 = q.es1;
        d.es3 = q.es2;
        d.oe1 = square_wave_enable_pin;
        d.oe2 = q.oe1;
        xtal_edge = q.xs2 & ~q.xs3;
        ext_edge = q.es2 & ~q.es3;
        wr_ctrl1 = reg_wr && (reg_addr == `OFF_TEST_HALT);
        wr_ctrl2 = reg_wr && (reg_addr == `OFF_IRQ_CTRL);

        // Control writes
        if (wr_ctrl1) begin
            d.external_tick_test_mode = reg_wdata[`BIT_TEST];
            d.halt = reg_wdata[`BIT_HALT];
        end
        if (reg_wr && reg_addr == `OFF_FREQ_SEL) begin
            d.output_freq_select = reg_wdata[1:0];
        end
        if (wr_ctrl2) begin
            d.irq_pulse_level_select = reg_wdata[`BIT_PULSE_SEL];
            d.alarm_irq_enable = reg_wdata[`BIT_ALARM_IE];
            d.countdown_irq_enable = reg_wdata[`BIT_COUNT_IE];
        end

        // Divide chain, test mode swaps the 64 Hz stage for the pin
        if (q.external_tick_test_mode) begin
            if (xtal_edge) begin
                d.presc[8:0] = q.presc[8:0] + 9'h001;
            end
            if (ext_edge) begin
                d.presc[14:9] = q.presc[14:9] + 6'h01;
            end
        end else if (xtal_edge) begin
            d.presc = q.presc + 15'h0001;
        end
        if (d.halt) begin
            d.presc[14:2] = 13'h0000;
        end
        d.tick = ~q.presc[14] & d.presc[14];

        // Sticky flags, set wins over clear
        timer_set = countdown_done && (countdown_value != 8'h00);
        d.alarm_event_flag = (q.alarm_event_flag &
            ~(wr_ctrl2 & ~reg_wdata[`BIT_ALARM_FLAG])) | alarm_event;
        d.countdown_event_flag = (q.countdown_event_flag &
            ~(wr_ctrl2 & ~reg_wdata[`BIT_COUNT_FLAG])) | timer_set;

        // Pulse width in crystal periods
        case (countdown_source_sel)
            src_4096: pulse_width = (countdown_value == 8'h01) ?
                10'(`PW_4096_ONE) : 10'(`PW_4096_MANY);
            src_64: pulse_width = (countdown_value == 8'h01) ?
                10'(`PW_64_ONE) : 10'(`PW_SLOW);
            default: pulse_width = 10'(`PW_SLOW);
        endcase
        if (timer_set) begin
            d.pulse_cnt = pulse_width;
        end else if (xtal_edge && q.pulse_cnt != 10'h000) begin
            d.pulse_cnt = q.pulse_cnt - 10'h001;
        end

        // Interrupt pin follows the next flag state
        timer_irq = d.irq_pulse_level_select ?
            (d.pulse_cnt != 10'h000) : d.countdown_event_flag;
        d.irq_oe_n = ~((d.countdown_irq_enable & timer_irq) |
            (d.alarm_irq_enable & d.alarm_event_flag));

        // Square wave, driven low only, released when off or in test
        case (d.output_freq_select)
            2'h0: wave = q.xs2;
            2'h1: wave = d.presc[4];
            2'h2: wave = d.presc[9];
            default: wave = d.presc[14];
        endcase
        d.sq_oe_n = ~(q.oe2 & ~d.external_tick_test_mode & ~wave);

        // Read back
        case (reg_addr)
            `OFF_TEST_HALT: d.rdata = {q.external_tick_test_mode, 1'b0,
                q.halt, 5'h00};
            `OFF_IRQ_CTRL: d.rdata = {3'h0, q.irq_pulse_level_select,
                q.alarm_event_flag, q.countdown_event_flag,
                q.alarm_irq_enable, q.countdown_irq_enable};
            `OFF_FREQ_SEL: d.rdata = {6'h00, q.output_freq_select};
            default: d.rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.output_freq_select <= `FREQ_SEL_RESET;
            q.sq_oe_n <= 1'b1;
            q.irq_oe_n <= 1'b1;
            q.es1 <= 1'b1;
            q.es2 <= 1'b1;
            q.es3 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign square_wave_pin_out = 1'b0;
    assign irq_pin_out = 1'b0;
    assign square_wave_pin_oe_n = q.sq_oe_n;
    assign irq_pin_oe_n = q.irq_oe_n;
    assign reg_rdata = q.rdata;
    assign second_tick = q.tick;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_alarm_set_wins: assert property (
        alarm_event |=> q.alarm_event_flag)
        else $error("alarm flag not set");
    a_alarm_clear: assert property (
        reg_wr && reg_addr == `OFF_IRQ_CTRL && !reg_wdata[3] && !alarm_event
        |=> !q.alarm_event_flag)
        else $error("alarm flag not cleared");
    a_count_keep: assert property (
        q.countdown_event_flag && reg_wr && reg_addr == `OFF_IRQ_CTRL &&
        reg_wdata[2] |=> q.countdown_event_flag)
        else $error("countdown flag lost on write of one");
    a_zero_no_flag: assert property (
        countdown_done && countdown_value == 8'h00 && !q.countdown_event_flag
        && !(reg_wr && reg_addr == `OFF_IRQ_CTRL) |=> !q.countdown_event_flag)
        else $error("zero count set the flag");
    a_pulse_together: assert property (
        $rose(q.countdown_event_flag) && q.irq_pulse_level_select &&
        q.countdown_irq_enable |-> !irq_pin_oe_n)
        else $error("pulse not with flag");
    a_level_irq: assert property (
        q.alarm_irq_enable && q.alarm_event_flag |-> !irq_pin_oe_n)
        else $error("alarm interrupt not driven");
    a_halt_chain: assert property (
        q.halt |-> q.presc[14:2] == 13'h0000 && !second_tick)
        else $error("chain runs during halt");
    a_tick_rise: assert property (
        second_tick |-> q.presc[14] && !$past(q.presc[14]))
        else $error("tick without rise of top stage");
    a_test_release: assert property (
        q.external_tick_test_mode |-> square_wave_pin_oe_n)
        else $error("pin driven in test mode");
    a_pulse_width: assert property (
        q.pulse_cnt != 10'h000 |-> q.pulse_cnt <= 10'(`PW_SLOW))
        else $error("pulse counter out of range");
    a_pins_low_only: assert property (
        !square_wave_pin_out && !irq_pin_out)
        else $error("open-drain pin driven high");
    a_sq_disabled: assert property (
        !q.oe2 |=> square_wave_pin_oe_n)
        else $error("square-wave pin driven while disabled");
    a_fast_wave: assert property (
        q.oe2 && !reg_wr && !q.external_tick_test_mode &&
        q.output_freq_select == 2'h0
        |=> square_wave_pin_oe_n == $past(q.xs2))
        else $error("fast wave not following crystal");
    a_khz_wave: assert property (
        q.oe2 && !reg_wr && !q.external_tick_test_mode &&
        q.output_freq_select == 2'h1
        |=> square_wave_pin_oe_n == q.presc[4])
        else $error("kilohertz wave not on its stage");
    a_32hz_wave: assert property (
        q.oe2 && !reg_wr && !q.external_tick_test_mode &&
        q.output_freq_select == 2'h2
        |=> square_wave_pin_oe_n == q.presc[9])
        else $error("32 Hz wave not on its stage");
    a_1hz_wave: assert property (
        q.oe2 && !reg_wr && !q.external_tick_test_mode &&
        q.output_freq_select == 2'h3
        |=> square_wave_pin_oe_n == q.presc[14])
        else $error("1 Hz wave not on its stage");
    a_halt_stops_wave: assert property (
        q.halt && q.oe2 && !reg_wr && !q.external_tick_test_mode &&
        q.output_freq_select != 2'h0 |=> !square_wave_pin_oe_n)
        else $error("slow wave runs during halt");
    a_low_stages_run: assert property (
        q.halt && q.xs2 && !q.xs3
        |=> q.presc[1:0] == 2'($past(q.presc[1:0]) + 2'h1))
        else $error("lowest stages stopped by halt");
    a_pin_clocks_top: assert property (
        q.external_tick_test_mode && !q.halt && !reg_wr && q.es2 && !q.es3
        |=> q.presc[14:9] == 6'($past(q.presc[14:9]) + 6'h01))
        else $error("pin edge did not step the top stages");
    a_top_ignores_xtal: assert property (
        q.external_tick_test_mode && !q.halt && !reg_wr && !(q.es2 && !q.es3)
        |=> $stable(q.presc[14:9]))
        else $error("top stages moved without pin edge");
    a_tick_single: assert property (
        second_tick |=> !second_tick)
        else $error("second tick longer than one cycle");
    a_alarm_sticky: assert property (
        q.alarm_event_flag && !(reg_wr && reg_addr == `OFF_IRQ_CTRL)
        |=> q.alarm_event_flag)
        else $error("alarm flag dropped without write");
    a_count_sticky: assert property (
        q.countdown_event_flag && !(reg_wr && reg_addr == `OFF_IRQ_CTRL)
        |=> q.countdown_event_flag)
        else $error("countdown flag dropped without write");
    a_count_set: assert property (
        countdown_done && countdown_value != 8'h00
        |=> q.countdown_event_flag)
        else $error("countdown flag not set");
    a_irq_masked: assert property (
        !q.alarm_irq_enable && !q.countdown_irq_enable |-> irq_pin_oe_n)
        else $error("interrupt driven with both sources masked");
    a_level_follow: assert property (
        !q.irq_pulse_level_select && q.countdown_irq_enable &&
        q.countdown_event_flag |-> !irq_pin_oe_n)
        else $error("level interrupt not following flag");
    a_pulse_ends: assert property (
        q.irq_pulse_level_select && !q.alarm_irq_enable &&
        q.pulse_cnt == 10'h000 |-> irq_pin_oe_n)
        else $error("pulse interrupt outlasts its counter");
    a_zero_no_pulse: assert property (
        countdown_done && countdown_value == 8'h00 &&
        q.pulse_cnt == 10'h000 |=> q.pulse_cnt == 10'h000)
        else $error("zero count started a pulse");
    a_short_pulse: assert property (
        countdown_done && countdown_value == 8'h01 &&
        countdown_source_sel == src_4096
        |=> q.pulse_cnt == 10'(`PW_4096_ONE))
        else $error("short pulse width wrong");
    a_slow_pulse: assert property (
        countdown_done && countdown_value != 8'h00 &&
        (countdown_source_sel == src_1 ||
        countdown_source_sel == src_sixtieth)
        |=> q.pulse_cnt == 10'(`PW_SLOW))
        else $error("slow source pulse width wrong");
    a_pulse_step: assert property (
        q.pulse_cnt != 10'h000 && !countdown_done && q.xs2 && !q.xs3
        |=> q.pulse_cnt == 10'($past(q.pulse_cnt) - 10'h001))
        else $error("pulse counter missed a crystal edge");

    c_tick: cover property (second_tick);
    c_pulse_irq: cover property (q.irq_pulse_level_select &&
        $fell(irq_pin_oe_n));
    c_test_tick: cover property (q.external_tick_test_mode && second_tick);
    c_halt_release: cover property ($fell(q.halt));
    c_alarm_irq: cover property (q.alarm_event_flag && !irq_pin_oe_n);

endmodule

// file: shared/rtc_prescaler_defines.svh
/*
 Offsets, field positions, reset values and pulse widths of the prescaler,
 square-wave output and interrupt flag block.
 Assumes a 32.768 kHz crystal and a serial interface core in the same clock.
*/
`ifndef RTC_PRESCALER_DEFINES_SVH
`define RTC_PRESCALER_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_TEST_HALT 4'h0
`define OFF_IRQ_CTRL 4'h1
`define OFF_FREQ_SEL 4'hd

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_TEST 7
`define BIT_HALT 5
`define BIT_PULSE_SEL 4
`define BIT_ALARM_FLAG 3
`define BIT_COUNT_FLAG 2
`define BIT_ALARM_IE 1
`define BIT_COUNT_IE 0

// ----------------------------------------------------------------------
// Reset values and prescaler width
// ----------------------------------------------------------------------
`define FREQ_SEL_RESET 2'h0
`define PRESC_WIDTH 15

// ----------------------------------------------------------------------
// Pulse widths in crystal periods
// ----------------------------------------------------------------------
`define XTAL_HZ 32768
`define PW_4096_ONE (`XTAL_HZ / 8192)
`define PW_4096_MANY (`XTAL_HZ / 4096)
`define PW_64_ONE (`XTAL_HZ / 128)
`define PW_SLOW (`XTAL_HZ / 64)

`endif

// file: shared/rtc_prescaler_pkg.sv
/*
 Types of the prescaler, square-wave output and interrupt flag block.
 Assumes the defines header is included by the design file.
*/
package rtc_prescaler_pkg;

    typedef enum logic [1:0] {
        src_4096 = 2'h0,
        src_64 = 2'h1,
        src_1 = 2'h2,
        src_sixtieth = 2'h3
    } count_src_t;

    typedef struct packed {
        logic xs1;
        logic xs2;
        logic xs3;
        logic es1;
        logic es2;
        logic es3;
        logic oe1;
        logic oe2;
        logic [14:0] presc;
        logic [1:0] output_freq_select;
        logic external_tick_test_mode;
        logic halt;
        logic alarm_event_flag;
        logic countdown_event_flag;
        logic alarm_irq_enable;
        logic countdown_irq_enable;
        logic irq_pulse_level_select;
        logic [9:0] pulse_cnt;
        logic tick;
        logic [7:0] rdata;
        logic sq_oe_n;
        logic irq_oe_n;
    } state_t;

endpackage

// file: verif/rtc_host_model.sv
/*
 Host model that writes and reads the control registers of the block.
 Assumes the register port is sampled on the rising edge of clk.
*/
`timescale 1ns/1ps

module rtc_host_model (
    input wire logic clk,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata
);
    // ------------------------------------------------------------
    // Register cycles
    // ------------------------------------------------------------
    initial begin
        reg_addr = 4'hf;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        @(posedge clk);
        @(posedge clk);
        #1 d = reg_rdata;
    endtask

    // Clears flags at zero bits of keep, rest written back
    task automatic clear_flags(input logic [7:0] keep);
        logic [7:0] v;
        rd(4'h1, v);
        wr(4'h1, v & keep);
    endtask
endmodule

// file: verif/rtc_prescaler_square_wave_pin_irq_test.sv
/*
 Self-checking bench of the prescaler, square-wave pin and irq flags.
 Assumes the host model owns the register port; pins have pull-ups.
*/
`timescale 1ns/1ps
`include "rtc_prescaler_defines.svh"

module rtc_prescaler_square_wave_pin_irq_test;
    import rtc_prescaler_pkg::*;
    logic clk = 0, rstn = 0, xtal_in = 0, ext_level = 1, oe_pin = 1;
    logic alarm_event = 0, countdown_done = 0;
    logic [7:0] cnt_val = 8'h01, v;
    count_src_t src = src_4096;
    logic sq_out, sq_oe_n, irq_out, irq_oe_n, reg_wr, tick;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    int miscompares = 0, n_tests = 0, xcnt = 0, ticks = 0, p, t0;
    wire pin = sq_oe_n & ext_level;
    localparam logic [7:0] tst = 8'h1 << `BIT_TEST;
    localparam logic [7:0] hlt = 8'h1 << `BIT_HALT;
    int per[3] = '{1, 32768 / 1024, 32768 / 32};
    count_src_t cs[6] = '{src_4096, src_4096, src_64, src_64, src_1,
        src_sixtieth};
    logic [7:0] cn[6] = '{8'h01, 8'h05, 8'h01, 8'h02, 8'h09, 8'h03};
    int cw[6] = '{`PW_4096_ONE, `PW_4096_MANY, `PW_64_ONE, `PW_SLOW,
        `PW_SLOW, `PW_SLOW};

    rtc_host_model host (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata));
    rtc_prescaler uut (.clk(clk), .rstn(rstn), .xtal_in(xtal_in),
        .square_wave_enable_pin(oe_pin), .square_wave_pin_in(pin),
        .square_wave_pin_out(sq_out), .square_wave_pin_oe_n(sq_oe_n),
        .irq_pin_out(irq_out), .irq_pin_oe_n(irq_oe_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .alarm_event(alarm_event),
        .countdown_done(countdown_done), .countdown_source_sel(src),
        .countdown_value(cnt_val), .second_tick(tick));

    // ------------------------------------------------------------
    // Clocks, counters and helpers
    // ------------------------------------------------------------
    initial forever #2.5 clk = ~clk;
    initial begin
        #1;
        forever #20 xtal_in = ~xtal_in;
    end
    always @(posedge xtal_in) xcnt++;
    always @(posedge clk) if (tick === 1'b1) ticks++;

    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic rchk(string nm, logic [3:0] a, logic [7:0] e);
        host.rd(a, v);
        chk(nm, v, e);
    endtask
    task automatic irq_is(logic e);
        repeat (3) @(negedge clk);
        chk("irq_oe_n", irq_oe_n, e);
    endtask
    task automatic rise_sq();
        for (int i = 0; i < 20000 && sq_oe_n !== 1'b0; i++) @(negedge clk);
        for (int i = 0; i < 20000 && sq_oe_n !== 1'b1; i++) @(negedge clk);
    endtask
    task automatic sq_period(output int n);
        rise_sq();
        n = xcnt;
        rise_sq();
        n = xcnt - n;
    endtask
    task automatic count_low(int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if (sq_oe_n === 1'b0) c++;
        end
    endtask
    task automatic event_pulse(logic alarm);
        @(negedge clk);
        if (alarm) alarm_event = 1;
        else countdown_done = 1;
        @(negedge clk);
        alarm_event = 0;
        countdown_done = 0;
    endtask
    task automatic pin_edges(int n);
        repeat (n) begin
            @(negedge clk) ext_level = 0;
            repeat (4) @(negedge clk);
            ext_level = 1;
            repeat (4) @(negedge clk);
        end
        repeat (8) @(negedge clk);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1;
        chk("pins", {sq_out, irq_out}, 0);
        rchk("freq", `OFF_FREQ_SEL, 8'h00);
        rchk("ctrl2", `OFF_IRQ_CTRL, 8'h00);
        host.wr(4'h5, 8'hff);
        rchk("unmapped", 4'h5, 8'h00);
        host.wr(`OFF_FREQ_SEL, 8'hff);
        rchk("freq", `OFF_FREQ_SEL, 8'h03);
        for (int k = 0; k < 3; k++) begin
            host.wr(`OFF_FREQ_SEL, 8'(k));
            sq_period(p);
            chk("period", p, per[k]);
        end
        host.wr(`OFF_FREQ_SEL, 8'h00);
        oe_pin = 0;
        repeat (4) @(negedge clk);
        count_low(64, p);
        chk("disabled", p, 0);
        oe_pin = 1;
        host.wr(`OFF_FREQ_SEL, 8'h01);
        host.wr(`OFF_TEST_HALT, hlt);
        count_low(400, p);
        chk("halt_slow", p, 400);
        host.wr(`OFF_FREQ_SEL, 8'h00);
        sq_period(p);
        chk("halt_fast", p, 1);
        host.wr(`OFF_TEST_HALT, 8'h00);
        event_pulse(1'b1);
        irq_is(1);
        cnt_val = 8'h05;
        event_pulse(1'b0);
        rchk("flags", `OFF_IRQ_CTRL, 8'h0c);
        host.clear_flags(8'hf7);
        rchk("alarm_clr", `OFF_IRQ_CTRL, 8'h04);
        host.wr(`OFF_IRQ_CTRL, 8'h05);
        irq_is(0);
        host.clear_flags(8'hfb);
        irq_is(1);
        event_pulse(1'b1);
        irq_is(1);
        host.wr(`OFF_IRQ_CTRL, 8'h0b);
        irq_is(0);
        host.clear_flags(8'hf7);
        irq_is(1);
        host.wr(`OFF_IRQ_CTRL, 8'h11);
        for (int k = 0; k < 6; k++) begin
            src = cs[k];
            cnt_val = cn[k];
            @(negedge xtal_in);
            event_pulse(1'b0);
            @(negedge clk);
            chk("pulse_on", irq_oe_n, 0);
            t0 = xcnt;
            for (int i = 0; i < 5000 && irq_oe_n !== 1'b1; i++)
                @(negedge clk);
            chk("width", xcnt - t0, cw[k]);
            rchk("cd_flag", `OFF_IRQ_CTRL, 8'h15);
            host.clear_flags(8'hfb);
        end
        cnt_val = 8'h00;
        event_pulse(1'b0);
        irq_is(1);
        rchk("cd_zero", `OFF_IRQ_CTRL, 8'h11);
        host.wr(`OFF_TEST_HALT, tst);
        count_low(8, p);
        chk("test_oe", p, 0);
        host.wr(`OFF_TEST_HALT, tst | hlt);
        t0 = ticks;
        pin_edges(64);
        chk("halt_ticks", ticks - t0, 0);
        host.wr(`OFF_TEST_HALT, tst);
        pin_edges(31);
        chk("tick31", ticks - t0, 0);
        pin_edges(1);
        chk("tick32", ticks - t0, 1);
        pin_edges(63);
        chk("tick95", ticks - t0, 1);
        pin_edges(1);
        chk("tick96", ticks - t0, 2);
        final_report();
    end
endmodule
